// File: src/rcs_sequencer.sv
/*
  Radio channel sequencer: host-side controller for a narrow-band
  transceiver module with an internal synthesizer. Software drives it
  over a classic Wishbone slave; it drives supply, select lines,
  serial load lines and the transmit data pin, and samples lock and
  receive data pins through two-flop synchronisers.
  Assumes one 40 MHz clock and a synchronous active-high reset.
*/
// Behaviour
// - after reset, supply and both selects inactive, then supply on.
// - after first load following power-up, wait 40 ms before radio data.
// - later channel changes wait 20 ms after the load before data.
// - channel loads happen only in receive, never with transmit active.
// - receive on an unchanged channel needs no load; data within 5 ms.
// - transmit channel loaded in receive; send data 5 ms after switching.
// - 20 ms after each channel change, check lock detect is high.
// - lock detect may glitch early; only a stable high counts.
// - one-zero preamble for 15 ms right after entering transmit; the code starts it 5 ms after switching.
// - configurable extra receive margin for late data when cold.
// - synthesizer target is channel frequency minus 21.7 MHz offset.
// - reference counter loaded with 1700 for 12.5 kHz comparison.
// - 12.5 kHz channel step adds one to division number; 50 channels.
// - programmable counter is division number divided by 64.
// - swallow counter is division number modulo 64, wraps into P.
// - synthesizer takes one data bit per rising serial clock edge.
// - latch strobe moves 19-bit word to latch picked by last bit.
// - reference word prefixed with current 0, lock output 0, polarity 1.
`include "rcs_defines.svh"
`default_nettype none

module rcs_sequencer
  import rcs_pkg::*;
#(
  parameter int       CYC_PER_MS  = `RCS_MS_CYC,
  parameter int       BIT_CYC     = `RCS_BIT_CYC,
  parameter int       LOCK_CYC    = `RCS_LOCK_STABLE_CYC,
  parameter int       NUM_CHAN    = `RCS_NUM_CHAN,
  parameter bit [8:0] FIRST_MS    = 9'(`RCS_FIRST_MS),
  parameter bit [8:0] NEXT_MS     = 9'(`RCS_NEXT_MS),
  parameter bit [8:0] LOCK_MS     = 9'(`RCS_LOCK_MS),
  parameter bit [8:0] SWITCH_MS   = 9'(`RCS_SWITCH_MS),
  parameter bit [8:0] PREAMBLE_MS = 9'(`RCS_PREAMBLE_MS)
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // module power and selects, selects low active on the pin
  output logic             supply_en_o,
  output logic             receive_select_n_o,
  output logic             transmit_select_n_o,
  // synthesizer serial lines
  output rcs_serial_t      pll_o,
  // radio data and lock pins
  output logic             tx_bit_in_o,
  input  wire logic        rx_data_i,
  input  wire logic        lock_flag_out_i
);

  typedef struct packed {
    rcs_state_t  st;
    logic        lk1, lk2, rd1, rd2;
    logic [15:0] lock_run;
    logic        supply_en, rx_sel_n, tx_sel_n, tx_bit;
    logic        pwr, tx_req, payload;
    logic [5:0]  chan;
    logic [7:0]  margin;
    logic        pend, ready, fail, first_done;
    logic [8:0]  ms;
    logic [15:0] bitdiv;
    logic        tclr, ld_start;
    logic [18:0] ld_word;
    logic        ack;
    logic [31:0] dat;
  } rcs_seq_t;

  rcs_seq_t r, next_r;
  logic     tick_raw, tick, ld_busy, ld_done, lock_ok, wr, rd_hit;
  rcs_div_t cur_div;

  // division number split into programmable and swallow parts
  function automatic rcs_div_t div_split(input logic [5:0] ch);
    logic [15:0] n;
    rcs_div_t    d;
    n   = 16'(`RCS_N_BASE) + {10'h000, ch};
    d.p = {1'b0, n[15:`RCS_PRESCALE_LOG2]};
    d.s = {1'b0, n[`RCS_PRESCALE_LOG2-1:0]}; // wraps into p
    return d;
  endfunction

  // settling time in ms, with the cold margin on receive
  function automatic logic [8:0] settle_ms(input logic first,
                                           input logic [7:0] mg);
    return (first ? FIRST_MS : NEXT_MS) + {1'b0, mg};
  endfunction

  assign cur_div = div_split(r.chan);
  assign lock_ok = (r.lock_run >= 16'(LOCK_CYC));
  assign wr      = cyc_i && stb_i && we_i && !r.ack;
  assign rd_hit  = cyc_i && stb_i && !we_i && !r.ack;
  // a tick in flight as a wait starts would cut that wait by one ms
  assign tick    = tick_raw && !r.tclr;

  rcs_ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (r.tclr),
    .tick_o  (tick_raw)
  );

  rcs_serial_loader u_loader (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (r.ld_start),
    .word_i  (r.ld_word),
    .busy_o  (ld_busy),
    .done_o  (ld_done),
    .ser_o   (pll_o)
  );

  // sequencer, register file and pin synchronisers
  always_comb begin
    next_r          = r;
    next_r.tclr     = 1'b0;
    next_r.ld_start = 1'b0;
    next_r.ack      = 1'b0;
    // two-flop synchronisers, second stage feeds logic
    next_r.lk1 = lock_flag_out_i;
    next_r.lk2 = r.lk1;
    next_r.rd1 = rx_data_i;
    next_r.rd2 = r.rd1;
    // any low resets the run, so early glitches never pass
    if (!r.lk2) begin
      next_r.lock_run = 16'h0000;
    end else if (!lock_ok) begin
      next_r.lock_run = r.lock_run + 16'h0001;
    end
    if (tick) begin
      next_r.ms = r.ms + 9'h001; // own clock counts every wait
    end

    case (r.st)
      M_INIT: begin
        // pins parked inactive before power is allowed
        next_r.supply_en = 1'b0;
        next_r.rx_sel_n  = 1'b1;
        next_r.tx_sel_n  = 1'b1;
        next_r.st        = M_OFF;
      end
      M_OFF: begin
        if (r.pwr) begin
          next_r.supply_en = 1'b1;
          next_r.rx_sel_n  = 1'b0;
          next_r.first_done = 1'b0;
          next_r.pend      = 1'b0;
          next_r.st        = M_RX_READY;
          next_r.ld_start  = 1'b0;
          next_r.pend      = 1'b1; // first load follows power-up
        end
      end
      M_LOAD_REF: begin
        if (ld_done) begin
          next_r.ld_word  = {cur_div.p, cur_div.s, `RCS_TARGET_CNT};
          next_r.ld_start = 1'b1;
          next_r.st       = M_LOAD_CNT;
        end
      end
      M_LOAD_CNT: begin
        if (ld_done) begin
          next_r.ms   = 9'h000;
          next_r.tclr = 1'b1;
          next_r.st   = M_SETTLE;
        end
      end
      M_SETTLE: begin
        if (tick) begin
          if (r.ms + 9'h001 == LOCK_MS && !lock_ok) begin
            next_r.fail = 1'b1;
            next_r.st   = M_FAIL;
          end else if (r.ms + 9'h001 >=
                       settle_ms(!r.first_done, r.margin)) begin
            next_r.ready      = 1'b1;
            next_r.first_done = 1'b1;
            next_r.st         = M_RX_READY;
          end
        end
      end
      M_RX_READY, M_FAIL: begin
        if (r.pend && !ld_busy) begin
          // load only in receive, transmit held off
          next_r.pend     = 1'b0;
          next_r.ready    = 1'b0;
          next_r.fail     = 1'b0;
          next_r.ld_word  = {1'b0, `RCS_CUR_SEL, `RCS_LOCK_FN,
                             `RCS_PHASE_POL, 14'(`RCS_REF_DIV),
                             `RCS_TARGET_REF};
          next_r.ld_start = 1'b1;
          next_r.st       = M_LOAD_REF;
        end else if (r.st == M_RX_READY && r.tx_req && !r.fail) begin
          next_r.rx_sel_n = 1'b1;
          next_r.tx_sel_n = 1'b0;
          next_r.ready    = 1'b0;
          next_r.ms       = 9'h000;
          next_r.tclr     = 1'b1;
          next_r.st       = M_TX_SETTLE;
        end
      end
      M_TX_SETTLE: begin
        if (tick && r.ms + 9'h001 >= SWITCH_MS) begin
          next_r.ms     = 9'h000;
          next_r.tclr   = 1'b1;
          next_r.bitdiv = 16'h0000;
          next_r.tx_bit = 1'b1; // preamble starts on a one
          next_r.st     = M_PREAMBLE;
        end
      end
      M_PREAMBLE: begin
        if (r.bitdiv == 16'(BIT_CYC - 1)) begin
          next_r.bitdiv = 16'h0000;
          next_r.tx_bit = !r.tx_bit;
        end else begin
          next_r.bitdiv = r.bitdiv + 16'h0001;
        end
        if (tick && r.ms + 9'h001 >= PREAMBLE_MS) begin
          next_r.ready = 1'b1;
          next_r.st    = M_TX_DATA;
        end
      end
      M_TX_DATA: begin
        next_r.tx_bit = r.payload;
      end
      M_RX_SETTLE: begin
        // unchanged channel, no load needed
        if (tick && r.ms + 9'h001 >= SWITCH_MS + {1'b0, r.margin}) begin
          next_r.ready = 1'b1;
          next_r.st    = M_RX_READY;
        end
      end
      default: next_r.st = M_INIT;
    endcase

    // leave transmit before a channel change or on request
    if ((r.st == M_TX_SETTLE || r.st == M_PREAMBLE ||
         r.st == M_TX_DATA) && (!r.tx_req || r.pend)) begin
      next_r.tx_sel_n = 1'b1;
      next_r.rx_sel_n = 1'b0;
      next_r.tx_bit   = 1'b0;
      next_r.ready    = 1'b0;
      next_r.ms       = 9'h000;
      next_r.tclr     = 1'b1;
      next_r.st       = M_RX_SETTLE;
    end

    // power removal parks supply, both selects and the transmit data pin
    if (!r.pwr && r.st != M_INIT && r.st != M_OFF) begin
      next_r.supply_en = 1'b0;
      next_r.rx_sel_n  = 1'b1;
      next_r.tx_sel_n  = 1'b1;
      next_r.tx_bit    = 1'b0;
      next_r.ready     = 1'b0;
      next_r.st        = M_OFF;
    end

    // register writes take effect on the acknowledged edge
    if (wr && sel_i[0]) begin
      case (adr_i)
        `RCS_ADR_CTRL: begin
          next_r.pwr     = dat_i[`RCS_CTRL_PWR];
          next_r.tx_req  = dat_i[`RCS_CTRL_TX];
          next_r.payload = dat_i[`RCS_CTRL_PAY];
        end
        `RCS_ADR_CHAN: begin
          // out-of-plan channels ignored
          if (dat_i[7:0] < 8'(NUM_CHAN)) begin
            next_r.chan = dat_i[5:0];
            next_r.pend = 1'b1; // set wins over the sequencer's clear
          end
        end
        `RCS_ADR_MARGIN: next_r.margin = dat_i[7:0];
        default: ;
      endcase
    end

    // single-cycle acknowledge, unmapped reads give zero
    if (wr || rd_hit) begin
      next_r.ack = 1'b1;
      next_r.dat = 32'h00000000;
      if (!we_i) begin
        case (adr_i)
          `RCS_ADR_CTRL: begin
            next_r.dat[`RCS_CTRL_PWR] = r.pwr;
            next_r.dat[`RCS_CTRL_TX]  = r.tx_req;
            next_r.dat[`RCS_CTRL_PAY] = r.payload;
          end
          `RCS_ADR_CHAN:   next_r.dat[5:0] = r.chan;
          `RCS_ADR_MARGIN: next_r.dat[7:0] = r.margin;
          `RCS_ADR_STATUS: begin
            next_r.dat[`RCS_ST_READY] = r.ready;
            next_r.dat[`RCS_ST_FAIL]  = r.fail;
            next_r.dat[`RCS_ST_FIRST] = r.first_done;
            next_r.dat[`RCS_ST_LOCK]  = r.lk2;
            next_r.dat[`RCS_ST_RXD]   = r.rd2;
            next_r.dat[`RCS_ST_PEND]  = r.pend;
            next_r.dat[`RCS_ST_STATE +: 4] = r.st;
          end
          `RCS_ADR_DIV: begin
            next_r.dat[6:0] = cur_div.s;
            next_r.dat[`RCS_DIV_P +: 11] = cur_div.p;
          end
          default: ;
        endcase
      end
    end
  end

  // state register, reset parks all pins inactive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r          <= '0;
      r.st       <= M_INIT;
      r.rx_sel_n <= 1'b1;
      r.tx_sel_n <= 1'b1;
      r.chan     <= `RCS_CHAN_RST;
      r.margin   <= `RCS_MARGIN_RST;
    end else begin
      r <= next_r;
    end
  end

  assign dat_o               = r.dat;
  assign ack_o               = r.ack;
  assign supply_en_o         = r.supply_en;
  assign receive_select_n_o  = r.rx_sel_n;
  assign transmit_select_n_o = r.tx_sel_n;
  assign tx_bit_in_o         = r.tx_bit;

endmodule

`default_nettype wire

// File: inc/rcs_defines.svh
/*
  Constants for the radio channel sequencer: timing, divider plan,
  operation bits and software register offsets.
  Assumes a 40 MHz system clock; frequencies are held in 100 Hz units.
*/
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// clock and derived cycle counts
`define RCS_CLK_HZ          40000000
`define RCS_MS_CYC          (`RCS_CLK_HZ / 1000)
`define RCS_BAUD            4800
`define RCS_BIT_CYC         (`RCS_CLK_HZ / `RCS_BAUD)
`define RCS_LOCK_STABLE_US  100
`define RCS_LOCK_STABLE_CYC ((`RCS_CLK_HZ / 1000000) * `RCS_LOCK_STABLE_US)
`define RCS_SCLK_HALF       4

// settling waits in ms
`define RCS_FIRST_MS        40
`define RCS_NEXT_MS         20
`define RCS_LOCK_MS         20
`define RCS_SWITCH_MS       5
`define RCS_PREAMBLE_MS     15

// divider plan, frequencies in 100 Hz units
`define RCS_FREF_100HZ      212500
`define RCS_FCOMP_100HZ     125
`define RCS_FOFFSET_100HZ   217000
`define RCS_FCH0_100HZ      4580000
`define RCS_REF_DIV         (`RCS_FREF_100HZ / `RCS_FCOMP_100HZ)
`define RCS_N_BASE  ((`RCS_FCH0_100HZ - `RCS_FOFFSET_100HZ) / `RCS_FCOMP_100HZ)
`define RCS_PRESCALE_LOG2   6
`define RCS_NUM_CHAN        50

// operation bits ahead of the reference value; latch target bit goes last
`define RCS_CUR_SEL         1'b0
`define RCS_LOCK_FN         1'b0
`define RCS_PHASE_POL       1'b1
`define RCS_TARGET_REF      1'b1
`define RCS_TARGET_CNT      1'b0

// register byte offsets
`define RCS_ADR_CTRL        8'h00
`define RCS_ADR_CHAN        8'h04
`define RCS_ADR_MARGIN      8'h08
`define RCS_ADR_STATUS      8'h0c
`define RCS_ADR_DIV         8'h10

// field positions
`define RCS_CTRL_PWR        0
`define RCS_CTRL_TX         1
`define RCS_CTRL_PAY        2
`define RCS_ST_READY        0
`define RCS_ST_FAIL         1
`define RCS_ST_FIRST        2
`define RCS_ST_LOCK         3
`define RCS_ST_RXD          4
`define RCS_ST_PEND         5
`define RCS_ST_STATE        8
`define RCS_DIV_P           16

// reset values
`define RCS_CHAN_RST        6'h00
`define RCS_MARGIN_RST      8'h00

`endif

// File: inc/rcs_pkg.sv
/*
  Types for the radio channel sequencer.
  Assumes rcs_defines.svh for all numeric constants.
*/
`default_nettype none

package rcs_pkg;

  // serial synthesizer load lines
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic latch_strobe;
  } rcs_serial_t;

  // divider split of one channel
  typedef struct packed {
    logic [10:0] p;
    logic [6:0]  s;
  } rcs_div_t;

  typedef enum logic [1:0] {
    L_IDLE, L_LOW, L_HIGH, L_STROBE
  } rcs_ld_state_t;

  typedef enum logic [3:0] {
    M_INIT, M_OFF, M_LOAD_REF, M_LOAD_CNT, M_SETTLE, M_RX_READY,
    M_FAIL, M_TX_SETTLE, M_PREAMBLE, M_TX_DATA, M_RX_SETTLE
  } rcs_state_t;

endpackage

`default_nettype wire

// File: src/rcs_ms_timer.sv
/*
  Millisecond tick divider for the sequencer's settling waits.
  Assumes one clock; clear_i restarts the count so the first tick
  lands exactly one ms later.
*/
`include "rcs_defines.svh"
`default_nettype none

module rcs_ms_timer
  import rcs_pkg::*;
#(
  parameter int CYC_PER_MS = `RCS_MS_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control and tick
  input  wire logic clear_i,
  output logic      tick_o
);

  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } rcs_tmr_t;

  rcs_tmr_t r, next_r;

  // count cycles, one pulse per ms
  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (clear_i) begin
      next_r.cnt = 24'h000000;
    end else if (r.cnt == 24'(CYC_PER_MS - 1)) begin
      next_r.cnt  = 24'h000000;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick_o = r.tick;

endmodule

`default_nettype wire

// File: src/rcs_serial_loader.sv
/*
  Serial loader: shifts one 19-bit word out MSB first, one bit per
  rising serial clock edge, then pulses the latch strobe.
  Assumes start_i only while busy_o is low.
*/
`include "rcs_defines.svh"
`default_nettype none

module rcs_serial_loader
  import rcs_pkg::*;
#(
  parameter int HALF_CYC = `RCS_SCLK_HALF
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // word request
  input  wire logic        start_i,
  input  wire logic [18:0] word_i,
  output logic             busy_o,
  output logic             done_o,
  // synthesizer lines
  output rcs_serial_t      ser_o
);

  typedef struct packed {
    rcs_ld_state_t st;
    logic [4:0]    bitn;
    logic [7:0]    div;
    logic [18:0]   sh;
    rcs_serial_t   ser;
    logic          done;
  } rcs_ld_t;

  rcs_ld_t r, next_r;
  logic    half_end;

  assign half_end = (r.div == 8'(HALF_CYC - 1));

  // bit sequencer, data set up a half period before each edge
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.div  = half_end ? 8'h00 : r.div + 8'h01;
    case (r.st)
      L_IDLE: begin
        next_r.div = 8'h00;
        if (start_i) begin
          next_r.sh        = word_i;
          next_r.ser.sdata = word_i[18];
          next_r.bitn      = 5'h00;
          next_r.st        = L_LOW;
        end
      end
      L_LOW: begin
        if (half_end) begin
          next_r.ser.sclk = 1'b1; // bit taken here
          next_r.st       = L_HIGH;
        end
      end
      L_HIGH: begin
        if (half_end) begin
          next_r.ser.sclk = 1'b0;
          if (r.bitn == 5'd18) begin
            next_r.ser.latch_strobe = 1'b1; // move 19 bits
            next_r.st               = L_STROBE;
          end else begin
            next_r.bitn      = r.bitn + 5'h01;
            next_r.sh        = {r.sh[17:0], 1'b0};
            next_r.ser.sdata = r.sh[17];
            next_r.st        = L_LOW;
          end
        end
      end
      L_STROBE: begin
        if (half_end) begin
          next_r.ser = '0;
          next_r.done = 1'b1;
          next_r.st   = L_IDLE;
        end
      end
      default: next_r = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy_o = (r.st != L_IDLE);
  assign done_o = r.done;
  assign ser_o  = r.ser;

endmodule

`default_nettype wire

// File: verification/rcs_radio_model.sv
/* Radio module model: synthesizer latches, lock pin, receive pin.
   Assumes the host's serial lines and the bench clock. */
`default_nettype none
module rcs_radio_model
  import rcs_pkg::*;
(
  // host side
  input  wire logic        clk_i,
  input  wire rcs_serial_t pll_i,
  input  wire logic        rx_sel_n_i,
  // bench: 0 locked, 1 unlocked, 2 chattering
  input  wire logic [1:0]  lock_mode_i,
  input  wire logic        rx_level_i,
  // pins and latches
  output logic             lock_o,
  output logic             rx_o,
  output logic [18:0]      ref_o,
  output logic [18:0]      cnt_o,
  output var int           loads_o
);
  logic [18:0] shift = '0;
  logic        tgl   = 1'b0;

  initial loads_o = 0;
  // one bit per rising serial clock edge
  always @(posedge pll_i.sclk) shift <= {shift[17:0], pll_i.sdata};
  // last bit picks the latch
  always @(posedge pll_i.latch_strobe) begin
    if (shift[0]) begin
      ref_o <= shift;
    end else begin
      cnt_o   <= shift;
      loads_o <= loads_o + 1;
    end
  end
  // chatter source, also what a released line shows
  always @(posedge clk_i) tgl <= ~tgl;
  // high when locked, low when unlocked, toggling when chattering
  assign lock_o = lock_mode_i == 2'd0 ? 1'b1 :
                  lock_mode_i == 2'd2 ? tgl : 1'b0;
  // data at once while receiving, noise otherwise
  assign rx_o = rx_sel_n_i ? tgl : rx_level_i;
endmodule
`default_nettype wire

// File: verification/rcs_sequencer_checker.sv
/* Checker for the sequencer's pins and bus handshake.
   Assumes binding onto the top module's ports. */
`default_nettype none
module rcs_sequencer_checker
  import rcs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        ack_o,
  input  wire logic        supply_en_o,
  input  wire logic        receive_select_n_o,
  input  wire logic        transmit_select_n_o,
  input  wire rcs_serial_t pll_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // serial clock high half and strobe pulse, four cycles each
  sequence s_sclk_half;
    pll_o.sclk [*4] ##1 !pll_o.sclk;
  endsequence
  sequence s_strobe;
    pll_o.latch_strobe [*4] ##1 !pll_o.latch_strobe;
  endsequence

  a_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> !supply_en_o && receive_select_n_o && transmit_select_n_o
      && pll_o == '0) else $error("pins not idle after reset");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_sel_exclusive: assert property (
    receive_select_n_o || transmit_select_n_o)
    else $error("both selects active");
  a_load_rx_only: assert property (
    pll_o.sclk || pll_o.latch_strobe |->
      !receive_select_n_o && transmit_select_n_o)
    else $error("load outside receive");
  a_sclk_width: assert property (
    $rose(pll_o.sclk) |-> s_sclk_half)
    else $error("serial clock high half wrong");
  a_sdata_hold: assert property (
    $rose(pll_o.sclk) |=> $stable(pll_o.sdata) [*3])
    else $error("data moved while clock high");
  a_strobe_width: assert property (
    $rose(pll_o.latch_strobe) |-> s_strobe)
    else $error("strobe width wrong");
  a_power_order: assert property (
    $rose(supply_en_o) |->
      $past(receive_select_n_o) && $past(transmit_select_n_o))
    else $error("supply on before selects idle");
  a_off_idle: assert property (
    !supply_en_o |-> receive_select_n_o && transmit_select_n_o)
    else $error("select active without supply");
endmodule

bind rcs_sequencer rcs_sequencer_checker chk_u (.clk_i, .rst_i, .cyc_i,
  .stb_i, .ack_o, .supply_en_o, .receive_select_n_o,
  .transmit_select_n_o, .pll_o);
`default_nettype wire

// File: verification/tb_rcs_sequencer.sv
/* Testbench: Wishbone tasks give orders, the radio model answers.
   Assumes shortened ms and bit counts set at the instance. */
`include "rcs_defines.svh"
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %0t: %0h vs %0h", $time, \
  g, e); end end
module tb_rcs_sequencer
  import rcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 40; // cycles per ms, shortened
  logic        clk, rst, cyc, stb, we, rx_level;
  logic        ack, supply, rx_n, tx_n, tx_bit, lock, rxd;
  logic [1:0]  lock_mode;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [18:0] ref_w, cnt_w, c;
  rcs_serial_t pll;
  int          loads, nl, t0, mismatches = 0, n_tests = 0;
  int          ncyc = 0, flips = 0;
  int          chans[3] = '{39, 40, 49};

  rcs_sequencer #(.CYC_PER_MS(MS), .BIT_CYC(5), .LOCK_CYC(4)) dut_u (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .supply_en_o(supply), .receive_select_n_o(rx_n),
    .transmit_select_n_o(tx_n), .pll_o(pll), .tx_bit_in_o(tx_bit),
    .rx_data_i(rxd), .lock_flag_out_i(lock));
  rcs_radio_model radio_u (.clk_i(clk), .pll_i(pll), .rx_sel_n_i(rx_n),
    .lock_mode_i(lock_mode), .rx_level_i(rx_level), .lock_o(lock),
    .rx_o(rxd), .ref_o(ref_w), .cnt_o(cnt_w), .loads_o(loads));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cycle count for settle times, edge count for the preamble
  always @(posedge clk) ncyc++;
  always @(tx_bit) flips++;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    give_verdict();
  endtask
  // one classic cycle, held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) hang();
    @(posedge clk);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // polling is bounded so a stuck sequencer ends the run
  task automatic wait_st(input int b, input logic v);
    int i;
    for (i = 0; i < 3000; i++) begin
      wb(1'b0, `RCS_ADR_STATUS, 32'h0);
      if (q[b] === v) break;
    end
    if (i == 3000) hang();
  endtask
  // ready no sooner than the settle time, and not long after
  task automatic ready_after(input int ms);
    wait_st(`RCS_ST_READY, 1'b1);
    `CHK(ncyc - t0 >= ms * MS && ncyc - t0 < ms * MS + 1000, 1'b1)
  endtask
  function automatic logic [18:0] cw(input int ch);
    int n;
    n = `RCS_N_BASE + ch;
    return {11'(n / 64), 7'(n % 64), 1'b0};
  endfunction

  initial begin
    {rst, cyc, stb, we, adr, wdat, rx_level, lock_mode} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({supply, rx_n, tx_n, pll}, 6'b011000)
    chk_reg(`RCS_ADR_CHAN, 32'h0);
    chk_reg(`RCS_ADR_MARGIN, 32'h0);
    chk_reg(8'h14, 32'h0);
    chk_reg(`RCS_ADR_DIV, {5'h0, 11'd545, 9'h0, 7'd24});
    $display("test reset done");
    wb(1'b1, `RCS_ADR_CTRL, 32'h1);
    t0 = ncyc;
    `CHK({supply, rx_n, tx_n}, 3'b101)
    ready_after(`RCS_FIRST_MS);
    `CHK(ref_w, {4'b0001, 14'd1700, 1'b1})
    `CHK(cnt_w, cw(0))
    `CHK(q[3:1], 3'b110)
    $display("test power-up done");
    // 39 to 40 crosses the swallow wrap; margin on the last
    foreach (chans[k]) begin
      if (k == 2) wb(1'b1, `RCS_ADR_MARGIN, 32'h3);
      wb(1'b1, `RCS_ADR_CHAN, 32'(chans[k]));
      t0 = ncyc;
      ready_after(`RCS_NEXT_MS + (k == 2 ? 3 : 0));
      c = cw(chans[k]);
      `CHK(cnt_w, c)
      chk_reg(`RCS_ADR_DIV, {5'h0, c[18:8], 9'h0, c[7:1]});
    end
    wb(1'b1, `RCS_ADR_CHAN, 32'd50);
    chk_reg(`RCS_ADR_CHAN, 32'd49);
    wb(1'b1, `RCS_ADR_MARGIN, 32'h0);
    $display("test channels done");
    flips = 0;
    wb(1'b1, `RCS_ADR_CTRL, 32'h7);
    t0 = ncyc;
    `CHK({rx_n, tx_n}, 2'b10)
    ready_after(`RCS_SWITCH_MS + `RCS_PREAMBLE_MS);
    `CHK(flips >= 119 && flips <= 122, 1'b1)
    `CHK(tx_bit, 1'b1)
    nl = loads;
    wb(1'b1, `RCS_ADR_CTRL, 32'h1);
    t0 = ncyc;
    `CHK({rx_n, tx_n}, 2'b01)
    ready_after(`RCS_SWITCH_MS);
    `CHK(loads, nl)
    for (int v = 1; v >= 0; v--) begin
      rx_level <= v[0];
      repeat (3) @(posedge clk);
      wb(1'b0, `RCS_ADR_STATUS, 32'h0);
      `CHK(q[4], v[0])
    end
    $display("test transmit done");
    lock_mode <= 2'd2;
    wb(1'b1, `RCS_ADR_CHAN, 32'd10);
    t0 = ncyc;
    wait_st(`RCS_ST_FAIL, 1'b1);
    `CHK(ncyc - t0 >= `RCS_LOCK_MS * MS, 1'b1)
    `CHK(q[`RCS_ST_READY], 1'b0)
    wb(1'b1, `RCS_ADR_CTRL, 32'h3);
    repeat (5) @(posedge clk);
    `CHK(tx_n, 1'b1)
    lock_mode <= 2'd0;
    wb(1'b1, `RCS_ADR_CTRL, 32'h1);
    wb(1'b1, `RCS_ADR_CHAN, 32'd11);
    t0 = ncyc;
    ready_after(`RCS_NEXT_MS);
    `CHK(q[1], 1'b0)
    wb(1'b1, `RCS_ADR_CTRL, 32'h0);
    `CHK({supply, rx_n, tx_n}, 3'b011)
    $display("test lock and power-off done");
    give_verdict();
  end
endmodule
`default_nettype wire
